// [bfsa_defines.vh]
// Constants for the BCD bit-range and stack arithmetic unit
`ifndef BFSA_DEFINES_VH
`define BFSA_DEFINES_VH
// Register byte offsets
`define BFSA_OFF_CMD      5'h00
`define BFSA_OFF_DISC_IN  5'h04
`define BFSA_OFF_ACC      5'h08
`define BFSA_OFF_STK1     5'h0c
`define BFSA_OFF_FLAGS    5'h10
`define BFSA_OFF_DISC_OUT 5'h14
// Command word fields
`define BFSA_CMD_OP_HI    2
`define BFSA_CMD_OP_LO    0
`define BFSA_CMD_ST_HI    12
`define BFSA_CMD_ST_LO    8
`define BFSA_CMD_LEN_HI   21
`define BFSA_CMD_LEN_LO   16
// Opcodes
`define BFSA_OP_NOP       3'h0
`define BFSA_OP_LOAD      3'h1
`define BFSA_OP_SUB       3'h2
`define BFSA_OP_MUL       3'h3
`define BFSA_OP_DIV       3'h4
`define BFSA_OP_ADDS      3'h5
`define BFSA_OP_OUT       3'h6
// Range length limits
`define BFSA_LEN_MAX32    6'h20
`define BFSA_LEN_MAX16    6'h10
`define BFSA_LEN_MIN      6'h01
// Flag bit positions
`define BFSA_FLG_ZERO     0
`define BFSA_FLG_BORROW   1
`define BFSA_FLG_CARRY    2
`define BFSA_FLG_NEG      3
`define BFSA_FLG_SIGNERR  4
`define BFSA_FLG_NONBCD   5
`define BFSA_FLG_OVRNG    6
`define BFSA_FLG_LENERR   7
`define BFSA_FLG_W        8
// Arithmetic constants
`define BFSA_DEC_LIMIT    32'h05f5e100
`define BFSA_LOW16        32'h0000ffff
`define BFSA_ZERO32       32'h00000000
`define BFSA_ONES32       32'hffffffff
`define BFSA_STK_DEPTH    8
`define BFSA_SIGN_BIT     31
`endif

// [bfsa_top.v]
// BCD bit-range and stack arithmetic unit with Avalon-MM register slave
`timescale 1ns/10ps
// Operation
// RULE1: Subtract bit-range BCD from accumulator, 32-bit
// RULE2: Subtract range length is one to thirty-two
// RULE3: Multiply accumulator by range operand, 16-bit
// RULE4: Multiply range length is one to sixteen
// RULE5: Divide accumulator by 1-16 bit range
// RULE6: Quotient to accumulator, remainder to stack top
// RULE7: Add accumulator and stack top, 32-bit BCD
// RULE8: After stack add, pop and shift up
// RULE9: Load pushes old accumulator onto stack
// RULE10: Zero flag when accumulator result is zero
// RULE11: Borrow flag on 32-bit subtract borrow
// RULE12: Carry flag on 32-bit stack add carry
// RULE13: Negative flag when accumulator is negative
// RULE14: Sign-error flag on wrong signed result sign
// RULE15: Non-BCD flag on invalid BCD operand
// RULE16: Overrange flag when divide operand unusable
// RULE17: Flags valid until next instruction drives them
// RULE18: Output copies low accumulator bits to range
// RULE19: Nibble above nine means non-BCD
// RULE20: Lowest bit is LSB, upper bits zero
// RULE21: Popped bottom stack level fills with zero
`include "bfsa_defines.vh"

module bfsa_top (
   input  wire        clk_in,
   input  wire        reset_in,
   input  wire [4:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output wire [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   output wire [31:0] acc_out,
   output wire [7:0]  flags_out,
   output wire [31:0] disc_out
);

   ////////////////////////////////////////////////////////////////////
   // Helper functions

   // True when every nibble holds a decimal digit
   function is_bcd;
      input [31:0] v;
      integer      i;
      begin
         is_bcd = 1'b1;
         for (i = 0; i < 8; i = i + 1) begin
            if (v[i*4 +: 4] > 4'h9) begin
               is_bcd = 1'b0; // RULE19
            end
         end
      end
   endfunction

   // Eight BCD digits to binary
   function [31:0] bcd_to_bin;
      input [31:0] v;
      integer      i;
      begin
         bcd_to_bin = `BFSA_ZERO32;
         for (i = 7; i >= 0; i = i - 1) begin
            bcd_to_bin = (bcd_to_bin * 32'd10) + {28'h0000000, v[i*4 +: 4]};
         end
      end
   endfunction

   // Binary below the decimal limit to eight BCD digits
   function [31:0] bin_to_bcd;
      input [31:0] v;
      integer      i;
      integer      j;
      reg   [31:0] b;
      begin
         b = `BFSA_ZERO32;
         for (i = 31; i >= 0; i = i - 1) begin
            for (j = 0; j < 8; j = j + 1) begin
               if (b[j*4 +: 4] > 4'h4) begin
                  b[j*4 +: 4] = b[j*4 +: 4] + 4'h3;
               end
            end
            b = {b[30:0], v[i]};
         end
         bin_to_bcd = b;
      end
   endfunction

   // Mask of the low len bits
   function [31:0] len_mask;
      input [5:0] len;
      begin
         if (len >= `BFSA_LEN_MAX32) begin
            len_mask = `BFSA_ONES32;
         end else begin
            len_mask = ~(`BFSA_ONES32 << len);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State

   reg  [31:0] acc_ff;                    // Accumulator
   reg  [31:0] stk_ff [0:`BFSA_STK_DEPTH-1]; // Stack, index 0 is level 1
   reg  [`BFSA_FLG_W-1:0] flg_ff;         // Status flags
   reg  [31:0] disc_in_ff;                // Discrete source image
   reg  [31:0] disc_out_ff;               // Discrete destination image
   reg  [31:0] rdata_ff;                  // Read data holding
   reg         ack_ff;                    // Access answered this cycle
   integer     k;                         // Stack loop index

   // Bus decode
   wire        req     = avs_read_in | avs_write_in;
   wire        wr_take = avs_write_in & ack_ff;
   wire [31:0] be_mask = {{8{avs_byteenable_in[3]}},
                          {8{avs_byteenable_in[2]}},
                          {8{avs_byteenable_in[1]}},
                          {8{avs_byteenable_in[0]}}};
   // A command runs once, at the taken edge, never in the wait cycle
   wire        cmd_go  = wr_take & (avs_address_in == `BFSA_OFF_CMD);

   // Command fields
   wire [2:0]  op  = avs_writedata_in[`BFSA_CMD_OP_HI:`BFSA_CMD_OP_LO];
   wire [4:0]  st  = avs_writedata_in[`BFSA_CMD_ST_HI:`BFSA_CMD_ST_LO];
   wire [5:0]  len = avs_writedata_in[`BFSA_CMD_LEN_HI:`BFSA_CMD_LEN_LO];

   ////////////////////////////////////////////////////////////////////
   // Operand assembly and arithmetic

   reg  [31:0] mask;       // Low len bits
   reg  [31:0] opnd;       // Assembled bit-range operand
   reg         len_ok;     // Length inside the op's limit
   reg  [31:0] a_bin;      // Accumulator in binary
   reg  [31:0] a16_bin;    // Low four digits in binary
   reg  [31:0] o_bin;      // Operand in binary
   reg  [31:0] s_bin;      // Stack top in binary
   reg  [31:0] res_bin;    // Result in binary
   reg  [31:0] rem_bin;    // Remainder in binary
   reg  [31:0] res;        // BCD result
   reg         bad;        // Non-BCD input seen
   reg         borrow;     // Subtract borrow
   reg         carry;      // Add carry
   reg         serr;       // Sign error
   reg         ovr;        // Divide overrange

   // Combinational datapath for the command on the bus
   always @* begin
      mask    = len_mask(len);
      opnd    = (disc_in_ff >> st) & mask; // RULE20
      len_ok  = (len >= `BFSA_LEN_MIN) &&
                (len <= (((op == `BFSA_OP_MUL) || (op == `BFSA_OP_DIV)) ?
                 `BFSA_LEN_MAX16 : `BFSA_LEN_MAX32)); // RULE2 RULE4
      a_bin   = bcd_to_bin(acc_ff);
      a16_bin = bcd_to_bin(acc_ff & `BFSA_LOW16);
      o_bin   = bcd_to_bin(opnd);
      s_bin   = bcd_to_bin(stk_ff[0]);
      res_bin = `BFSA_ZERO32;
      rem_bin = `BFSA_ZERO32;
      borrow  = 1'b0;
      carry   = 1'b0;
      serr    = 1'b0;
      ovr     = 1'b0;
      bad     = 1'b0;
      case (op)
         `BFSA_OP_SUB: begin
            bad = ~is_bcd(acc_ff) | ~is_bcd(opnd); // RULE15
            if (a_bin < o_bin) begin
               borrow  = 1'b1; // RULE11
               res_bin = `BFSA_DEC_LIMIT - (o_bin - a_bin);
            end else begin
               res_bin = a_bin - o_bin; // RULE1
            end
         end
         `BFSA_OP_MUL: begin
            bad     = ~is_bcd(acc_ff) | ~is_bcd(opnd); // RULE15
            res_bin = a16_bin * o_bin; // RULE3
         end
         `BFSA_OP_DIV: begin
            bad = ~is_bcd(acc_ff) | ~is_bcd(opnd); // RULE15
            ovr = (o_bin == `BFSA_ZERO32); // RULE16
            if (!ovr) begin
               res_bin = a16_bin / o_bin; // RULE5
               rem_bin = a16_bin % o_bin;
            end
         end
         `BFSA_OP_ADDS: begin
            bad     = ~is_bcd(acc_ff) | ~is_bcd(stk_ff[0]); // RULE15
            res_bin = a_bin + s_bin; // RULE7
            if (res_bin >= `BFSA_DEC_LIMIT) begin
               carry   = 1'b1; // RULE12
               res_bin = res_bin - `BFSA_DEC_LIMIT;
            end
         end
         default: begin
            res_bin = `BFSA_ZERO32;
         end
      endcase
      res = bin_to_bcd(res_bin);
      // Signed view of raw patterns
      if (op == `BFSA_OP_SUB) begin
         serr = (acc_ff[`BFSA_SIGN_BIT] != opnd[`BFSA_SIGN_BIT]) &&
                (res[`BFSA_SIGN_BIT] != acc_ff[`BFSA_SIGN_BIT]); // RULE14
      end else if (op == `BFSA_OP_ADDS) begin
         serr = (acc_ff[`BFSA_SIGN_BIT] == stk_ff[0][`BFSA_SIGN_BIT]) &&
                (res[`BFSA_SIGN_BIT] != acc_ff[`BFSA_SIGN_BIT]); // RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then the answer

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ack_ff   <= 1'b0;
         rdata_ff <= `BFSA_ZERO32;
      end else begin
         ack_ff <= req & ~ack_ff;
         // Capture read data during the wait cycle, so that it
         // already stands at the edge where the master takes it
         if (avs_read_in & ~ack_ff) begin
            case (avs_address_in)
               `BFSA_OFF_CMD:      rdata_ff <= `BFSA_ZERO32;
               `BFSA_OFF_DISC_IN:  rdata_ff <= disc_in_ff;
               `BFSA_OFF_ACC:      rdata_ff <= acc_ff;
               `BFSA_OFF_STK1:     rdata_ff <= stk_ff[0];
               `BFSA_OFF_FLAGS:    rdata_ff <= {24'h000000, flg_ff};
               `BFSA_OFF_DISC_OUT: rdata_ff <= disc_out_ff;
               default:            rdata_ff <= `BFSA_ZERO32;
            endcase
         end
      end
   end

   assign avs_waitrequest_out = req & ~ack_ff;
   assign avs_readdata_out    = rdata_ff;

   ////////////////////////////////////////////////////////////////////
   // Discrete source image written by software

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         disc_in_ff <= `BFSA_ZERO32;
      end else if (wr_take && (avs_address_in == `BFSA_OFF_DISC_IN)) begin
         disc_in_ff <= (disc_in_ff & ~be_mask) |
                       (avs_writedata_in & be_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Instruction execution: accumulator, stack, flags, outputs

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         acc_ff      <= `BFSA_ZERO32;
         flg_ff      <= {`BFSA_FLG_W{1'b0}};
         disc_out_ff <= `BFSA_ZERO32;
         for (k = 0; k < `BFSA_STK_DEPTH; k = k + 1) begin
            stk_ff[k] <= `BFSA_ZERO32;
         end
      end else if (cmd_go) begin
         // Only flags an instruction drives change; others hold
         if (!len_ok && (op != `BFSA_OP_ADDS) && (op != `BFSA_OP_NOP)) begin
            flg_ff[`BFSA_FLG_LENERR] <= 1'b1; // RULE2 RULE4
         end else begin
            case (op)
               `BFSA_OP_LOAD: begin
                  flg_ff[`BFSA_FLG_LENERR] <= 1'b0;
                  stk_ff[0] <= acc_ff; // RULE9
                  for (k = 1; k < `BFSA_STK_DEPTH; k = k + 1) begin
                     stk_ff[k] <= stk_ff[k-1];
                  end
                  acc_ff <= opnd;
               end
               `BFSA_OP_SUB: begin
                  flg_ff[`BFSA_FLG_LENERR] <= 1'b0;
                  flg_ff[`BFSA_FLG_NONBCD] <= bad;
                  if (!bad) begin
                     acc_ff <= res; // RULE1
                     flg_ff[`BFSA_FLG_ZERO]    <= (res == `BFSA_ZERO32); // RULE10
                     flg_ff[`BFSA_FLG_BORROW]  <= borrow; // RULE11
                     flg_ff[`BFSA_FLG_NEG]     <= res[`BFSA_SIGN_BIT]; // RULE13
                     flg_ff[`BFSA_FLG_SIGNERR] <= serr; // RULE14
                  end
               end
               `BFSA_OP_MUL: begin
                  flg_ff[`BFSA_FLG_LENERR] <= 1'b0;
                  flg_ff[`BFSA_FLG_NONBCD] <= bad;
                  if (!bad) begin
                     acc_ff <= res; // RULE3
                     flg_ff[`BFSA_FLG_ZERO] <= (res == `BFSA_ZERO32); // RULE10
                     flg_ff[`BFSA_FLG_NEG]  <= res[`BFSA_SIGN_BIT]; // RULE13
                  end
               end
               `BFSA_OP_DIV: begin
                  flg_ff[`BFSA_FLG_LENERR] <= 1'b0;
                  flg_ff[`BFSA_FLG_NONBCD] <= bad;
                  flg_ff[`BFSA_FLG_OVRNG]  <= ovr; // RULE16
                  if (!bad && !ovr) begin
                     acc_ff    <= res; // RULE6
                     stk_ff[0] <= bin_to_bcd(rem_bin); // RULE6
                     flg_ff[`BFSA_FLG_ZERO] <= (res == `BFSA_ZERO32); // RULE10
                     flg_ff[`BFSA_FLG_NEG]  <= res[`BFSA_SIGN_BIT]; // RULE13
                  end
               end
               `BFSA_OP_ADDS: begin
                  flg_ff[`BFSA_FLG_NONBCD] <= bad;
                  if (!bad) begin
                     acc_ff <= res; // RULE7
                     flg_ff[`BFSA_FLG_ZERO]    <= (res == `BFSA_ZERO32); // RULE10
                     flg_ff[`BFSA_FLG_CARRY]   <= carry; // RULE12
                     flg_ff[`BFSA_FLG_NEG]     <= res[`BFSA_SIGN_BIT]; // RULE13
                     flg_ff[`BFSA_FLG_SIGNERR] <= serr; // RULE14
                     // Drop level 1, move the rest up
                     for (k = 0; k < `BFSA_STK_DEPTH - 1; k = k + 1) begin
                        stk_ff[k] <= stk_ff[k+1]; // RULE8
                     end
                     stk_ff[`BFSA_STK_DEPTH-1] <= `BFSA_ZERO32; // RULE21
                  end
               end
               `BFSA_OP_OUT: begin
                  flg_ff[`BFSA_FLG_LENERR] <= 1'b0;
                  disc_out_ff <= (disc_out_ff & ~(mask << st)) |
                                 ((acc_ff & mask) << st); // RULE18
               end
               default: begin
                  flg_ff <= flg_ff;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Direct state outputs

   assign acc_out   = acc_ff;
   assign flags_out = flg_ff;
   assign disc_out  = disc_out_ff;

endmodule

// [bfsa_top_props.sv]
// Port assertions for the BCD bit-range and stack arithmetic unit
`timescale 1ns/10ps
`include "bfsa_defines.vh"
module bfsa_top_props (
   input wire        clk_in,
   input wire        reset_in,
   input wire [4:0]  avs_address_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0]  avs_byteenable_in,
   input wire [31:0] avs_readdata_out,
   input wire        avs_waitrequest_out,
   input wire [31:0] acc_out,
   input wire [7:0]  flags_out,
   input wire [31:0] disc_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   ////////////////////////////////////////////////////////////////////////
   // Command write taken, with its fields
   wire        take  = avs_write_in & ~avs_waitrequest_out &
                       (avs_address_in == `BFSA_OFF_CMD);
   wire [2:0]  op    = avs_writedata_in[2:0];
   wire [4:0]  st    = avs_writedata_in[12:8];
   wire [5:0]  len   = avs_writedata_in[21:16];
   wire        arith = take & (op >= `BFSA_OP_SUB) & (op <= `BFSA_OP_ADDS);
   // Op on the bus one edge back, so stale error flags excuse nothing
   reg  [2:0]  op_q  = 3'h0;
   always @(posedge clk_in) begin
      op_q <= op;
   end
   // Only error flags that this op itself drives excuse a check
   wire        err   = flags_out[5] |
                       (flags_out[7] & (op_q != `BFSA_OP_ADDS)) |
                       (flags_out[6] & (op_q == `BFSA_OP_DIV));
   wire        bad32 = (len == 6'h00) | (len > 6'h20);
   wire        bad16 = (len == 6'h00) | (len > 6'h10);
   // Low-bit mask of a range length
   wire [31:0] msk   = (len >= 6'h20) ? 32'hffffffff :
                       ((32'h1 << len) - 32'h1);
   ////////////////////////////////////////////////////////////////////////
   property p_wait;
      $rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out ##1
         !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not one cycle");
   property p_unmap;
      avs_read_in & ~avs_waitrequest_out & (avs_address_in > 5'h14) |->
         avs_readdata_out == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
   property p_flg_hold;
      !take |=> $stable(flags_out);
   endproperty
   a_flg_hold: assert property (p_flg_hold)
      else $error("flags moved without a command");
   property p_acc_hold;
      !take |=> $stable(acc_out) && $stable(disc_out);
   endproperty
   a_acc_hold: assert property (p_acc_hold)
      else $error("acc or disc moved without a command");
   property p_zero;
      arith |=> err || (flags_out[0] == (acc_out == 32'h0));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_neg;
      arith |=> err || (flags_out[3] == acc_out[31]);
   endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong");
   property p_out;
      take & (op == `BFSA_OP_OUT) & (len != 6'h00) &
         ({2'b00, st} + {1'b0, len} <= 7'h20) |=>
         (((disc_out >> $past(st)) ^ acc_out) & $past(msk)) == 32'h0;
   endproperty
   a_out: assert property (p_out) else $error("output range wrong");
   property p_len_sub;
      take & (op == `BFSA_OP_SUB) & bad32 |=> flags_out[7] && $stable(acc_out);
   endproperty
   a_len_sub: assert property (p_len_sub)
      else $error("bad subtract length accepted");
   property p_len_mul;
      take & ((op == `BFSA_OP_MUL) | (op == `BFSA_OP_DIV)) & bad16 |=>
         flags_out[7] && $stable(acc_out);
   endproperty
   a_len_mul: assert property (p_len_mul)
      else $error("bad multiply length accepted");
   // Main scenarios reached
   c_out: cover property (take & (op == `BFSA_OP_OUT));
   c_adds: cover property (take & (op == `BFSA_OP_ADDS));
   c_carry: cover property ($rose(flags_out[2]));
endmodule
bind bfsa_top bfsa_top_props u_props (
   .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .acc_out(acc_out),
   .flags_out(flags_out), .disc_out(disc_out)
);

// [bfsa_seq_model.sv]
// Instruction sequencer model driving the register bus
`timescale 1ns/10ps
module bfsa_seq_model (
   input  wire        clk_in,
   input  wire        waitrequest_in,
   input  wire [31:0] readdata_in,
   output reg  [4:0]  address_out,
   output reg         read_out,
   output reg         write_out,
   output reg  [31:0] writedata_out,
   output reg  [3:0]  byteenable_out
);
   // Idle bus from time zero
   initial begin
      address_out = 5'h00;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h0;
      byteenable_out = 4'hf;
   end
   // One access, held until waitrequest is sampled low
   task access(input logic wr, input logic [4:0] adr,
               input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge clk_in);
      address_out <= adr;
      writedata_out <= wdat;
      read_out <= ~wr;
      write_out <= wr;
      // Only the bench watchdog ends a wait that never answers
      do begin
         @(posedge clk_in);
      end while (waitrequest_in);
      // Read data taken before any later command moves it
      rdat = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      // Released lines stop showing the last value
      address_out <= ~adr;
      writedata_out <= ~wdat;
   endtask
endmodule

// [bfsa_top_bench.sv]
// Self-checking bench for the BCD arithmetic unit
`timescale 1ns/10ps
`include "bfsa_defines.vh"
module bfsa_top_bench;
   reg         clk_in = 1'b0;
   reg         reset_in = 1'b1;
   wire [4:0]  adr;
   wire        rd, wr, wt;
   wire [31:0] wdat, rdat, acc, disc;
   wire [3:0]  be;
   wire [7:0]  flg;
   integer     error_cnt = 0;
   integer     n_compared = 0;
   // 200 MHz clock
   always #2.5 clk_in = ~clk_in;
   bfsa_top dut (.clk_in(clk_in), .reset_in(reset_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
      .acc_out(acc), .flags_out(flg), .disc_out(disc));
   bfsa_seq_model u_seq (.clk_in(clk_in), .waitrequest_in(wt),
      .readdata_in(rdat), .address_out(adr), .read_out(rd),
      .write_out(wr), .writedata_out(wdat), .byteenable_out(be));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Compare of a word
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Compare of the flags under a mask
   task chk_flg(input logic [7:0] m, input logic [7:0] e);
      chk("flags", {24'h0, e}, {24'h0, flg & m});
   endtask
   // Source bits, then a command
   task opr(input logic [2:0] op, input logic [31:0] dv,
            input logic [4:0] st, input logic [5:0] ln);
      logic [31:0] d;
      u_seq.access(1'b1, `BFSA_OFF_DISC_IN, dv, d);
      u_seq.access(1'b1, `BFSA_OFF_CMD, {10'h0, ln, 3'h0, st, 5'h0, op}, d);
      @(posedge clk_in);
   endtask
   // Register read and compare
   task rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      u_seq.access(1'b0, a, 32'h0, d);
      chk(nm, e, d);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk("acc", 32'h0, acc);
      chk("disc", 32'h0, disc);
      chk_flg(8'hff, 8'h00);
      rd_chk("stack1", `BFSA_OFF_STK1, 32'h0);
      rd_chk("unmapped", 5'h18, 32'h0);
   endtask
   // Reset in mid-run clears accumulator, stack and flags again
   task t_rst_mid;
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      t_reset;
   endtask
   task t_sub;
      opr(`BFSA_OP_LOAD, 32'hf0123450, 5'h04, 6'h10);
      chk("acc", 32'h00002345, acc);
      opr(`BFSA_OP_LOAD, 32'h00000045, 5'h00, 6'h08);
      rd_chk("stack1", `BFSA_OFF_STK1, 32'h00002345);
      opr(`BFSA_OP_SUB, 32'hff000045, 5'h00, 6'h08);
      chk("acc", 32'h0, acc);
      chk_flg(8'h0b, 8'h01);
      opr(`BFSA_OP_SUB, 32'h00000003, 5'h00, 6'h01);
      chk("acc", 32'h99999999, acc);
      chk_flg(8'h0b, 8'h0a);
      opr(`BFSA_OP_SUB, 32'h00000001, 5'h00, 6'h20);
      chk("acc", 32'h99999998, acc);
      chk_flg(8'h8b, 8'h08);
      opr(`BFSA_OP_SUB, 32'h00000001, 5'h00, 6'h21);
      chk_flg(8'h80, 8'h80);
      opr(`BFSA_OP_SUB, 32'h0000001a, 5'h00, 6'h08);
      chk("acc", 32'h99999998, acc);
      chk_flg(8'h20, 8'h20);
   endtask
   task t_muldiv;
      opr(`BFSA_OP_LOAD, 32'h00000012, 5'h00, 6'h10);
      opr(`BFSA_OP_MUL, 32'h00340000, 5'h10, 6'h10);
      chk("acc", 32'h00000408, acc);
      opr(`BFSA_OP_MUL, 32'h00000002, 5'h00, 6'h11);
      chk("acc", 32'h00000408, acc);
      chk_flg(8'h80, 8'h80);
      opr(`BFSA_OP_LOAD, 32'h00000100, 5'h00, 6'h10);
      opr(`BFSA_OP_DIV, 32'h00000007, 5'h00, 6'h10);
      chk("acc", 32'h00000014, acc);
      rd_chk("stack1", `BFSA_OFF_STK1, 32'h00000002);
      opr(`BFSA_OP_DIV, 32'h00000000, 5'h00, 6'h04);
      chk("acc", 32'h00000014, acc);
      chk_flg(8'h40, 8'h40);
   endtask
   task t_add;
      opr(`BFSA_OP_LOAD, 32'h00000011, 5'h00, 6'h20);
      opr(`BFSA_OP_LOAD, 32'h40000000, 5'h00, 6'h20);
      opr(`BFSA_OP_LOAD, 32'h40000000, 5'h00, 6'h20);
      opr(`BFSA_OP_ADDS, 32'h0, 5'h00, 6'h00);
      chk("acc", 32'h80000000, acc);
      chk_flg(8'h1d, 8'h18);
      rd_chk("stack1", `BFSA_OFF_STK1, 32'h00000011);
      opr(`BFSA_OP_LOAD, 32'h99999999, 5'h00, 6'h20);
      opr(`BFSA_OP_LOAD, 32'h00000001, 5'h00, 6'h20);
      opr(`BFSA_OP_ADDS, 32'h0, 5'h00, 6'h00);
      chk("acc", 32'h0, acc);
      chk_flg(8'h1d, 8'h05);
   endtask
   task t_pop;
      repeat (9) opr(`BFSA_OP_LOAD, 32'h00000001, 5'h00, 6'h01);
      repeat (8) opr(`BFSA_OP_ADDS, 32'h0, 5'h00, 6'h00);
      chk("acc", 32'h00000009, acc);
      rd_chk("stack1", `BFSA_OFF_STK1, 32'h0);
   endtask
   task t_out;
      opr(`BFSA_OP_LOAD, 32'h00001234, 5'h00, 6'h10);
      opr(`BFSA_OP_OUT, 32'h0, 5'h08, 6'h08);
      chk("disc", 32'h00003400, disc);
      rd_chk("disc_rd", `BFSA_OFF_DISC_OUT, 32'h00003400);
      chk("acc", 32'h00001234, acc);
      opr(`BFSA_OP_NOP, 32'h0, 5'h00, 6'h00);
      chk("acc", 32'h00001234, acc);
      chk_flg(8'hff, 8'h40);
      rd_chk("flags_rd", `BFSA_OFF_FLAGS, 32'h00000040);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      t_reset;
      t_sub;
      t_muldiv;
      t_add;
      t_pop;
      t_out;
      t_rst_mid;
      print_verdict;
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      print_verdict;
   end
endmodule
